/* File: inc/fault_mon_pkg.sv */
package fault_mon_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CODE_W = 7;
  localparam int HIST_DEPTH = 10;
  localparam int HIST_IDX_W = 4;
  // clock and power-up timing
  localparam int CLK_MHZ = 40;
  localparam int INIT_TIME_US = 250;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int SYNC_STAGES = 2;
  // event codes
  localparam logic [CODE_W-1:0] CODE_DEV_ON = 7'h0A;
  localparam logic [CODE_W-1:0] CODE_DEV_OFF = 7'h0C;
  localparam logic [CODE_W-1:0] CODE_ABN_DATA = 7'h46;
  localparam logic [CODE_W-1:0] CODE_GEAR = 7'h47;
  localparam logic [CODE_W-1:0] CODE_RUN_SENSOR = 7'h1C;
  localparam logic [CODE_W-1:0] CODE_STORED_DATA = 7'h29;
  localparam logic [CODE_W-1:0] CODE_INIT_SENSOR = 7'h2A;
  localparam logic [CODE_W-1:0] CODE_INIT_ROTATION = 7'h2B;
  localparam logic [CODE_W-1:0] CODE_MOTOR_COMBO = 7'h2D;
  localparam logic [CODE_W-1:0] CODE_NONE = 7'h00;
  // limits
  localparam logic [15:0] INIT_SPEED_LIMIT_RPM = 16'h000F;
  localparam logic [31:0] GEAR_RES_MIN = 32'h0000_0064;
  localparam logic [31:0] GEAR_RES_MAX = 32'h0000_2710;
  // register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ALM_LIMIT_ON = 8'h04;
  localparam logic [ADDR_W-1:0] REG_WRN_LIMIT_ON = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LIMIT_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_DEVIATION = 8'h14;
  localparam logic [ADDR_W-1:0] REG_HIST_COUNT = 8'h18;
  localparam logic [ADDR_W-1:0] REG_HIST_BASE = 8'h40;
  // control bit positions
  localparam int CTRL_AUTO_RETURN = 0;
  localparam int CTRL_HIST_CLEAR = 1;
  localparam int CTRL_ALM_RESET = 2;
  // status bit positions
  localparam int STAT_WARNING = 0;
  localparam int STAT_ALARM = 1;
  localparam int STAT_INIT_DONE = 2;
  localparam int STAT_CURRENT_CUT = 3;
  localparam int STAT_CODE_LSB = 8;
  // reset values
  localparam logic [31:0] RST_ALM_LIMIT_ON = 32'h0000_2710;
  localparam logic [31:0] RST_WRN_LIMIT_ON = 32'h0000_1388;
  localparam logic [31:0] RST_LIMIT_OFF = 32'h0000_2710;
  localparam logic RST_AUTO_RETURN = 1'b0;
  // synchronised pin positions
  localparam int PIN_CURRENT_EN = 0;
  localparam int PIN_DEV_CLEAR = 1;
  localparam int PIN_ALM_RESET = 2;
  localparam int PIN_RETURN_HOME = 3;
  localparam int PIN_SENSOR_FAULT = 4;
  localparam int PIN_MOTOR_OK = 5;
  localparam int PIN_NVM_BAD = 6;
  localparam int PIN_ABN_WARN = 7;
  localparam int PIN_COUNT = 8;

  typedef enum logic {PHASE_INIT, PHASE_RUN} phase_t;
endpackage

/* File: src/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // pins
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // pin_sync
`default_nettype wire

/* File: src/warning_history.sv */
`timescale 1ns/1ps
`default_nettype none
module warning_history (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic clear_i,
  input wire logic push_i,
  input wire logic [fault_mon_pkg::CODE_W-1:0] code_i,
  // read side
  input wire logic [fault_mon_pkg::HIST_IDX_W-1:0] rd_idx_i,
  output logic [fault_mon_pkg::CODE_W-1:0] rd_code_o,
  output logic [fault_mon_pkg::HIST_IDX_W-1:0] count_o
);
  logic [fault_mon_pkg::CODE_W-1:0] entry [fault_mon_pkg::HIST_DEPTH];

  // entry 0 is newest; the oldest falls off the end when full
  genvar g;
  generate
    for (g = 0; g < fault_mon_pkg::HIST_DEPTH; g++) begin : g_entry
      if (g == 0) begin : g_head
        // a push in the clear cycle survives as the only entry
        always_ff @(posedge core_clk_i) begin
          if (sys_rst_i) begin
            entry[g] <= fault_mon_pkg::CODE_NONE;
          end else if (push_i) begin
            entry[g] <= code_i;
          end else if (clear_i) begin
            entry[g] <= fault_mon_pkg::CODE_NONE;
          end
        end
      end else begin : g_tail
        always_ff @(posedge core_clk_i) begin
          if (sys_rst_i || clear_i) begin
            entry[g] <= fault_mon_pkg::CODE_NONE;
          end else if (push_i) begin
            entry[g] <= entry[g-1];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      count_o <= '0;
    end else if (clear_i) begin
      count_o <= push_i ? 4'h1 : 4'h0;
    end else if (push_i && count_o != 4'(fault_mon_pkg::HIST_DEPTH)) begin
      count_o <= count_o + 4'h1;
    end
  end

  assign rd_code_o = (rd_idx_i < 4'(fault_mon_pkg::HIST_DEPTH)) ? entry[rd_idx_i]
                                                                : fault_mon_pkg::CODE_NONE;
endmodule // warning_history
`default_nettype wire

/* File: src/motor_fault_warning_monitor.sv */
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module motor_fault_warning_monitor #(
  parameter int INIT_CYCLES = fault_mon_pkg::INIT_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // host pins, asynchronous
  input wire logic current_enable_i,
  input wire logic deviation_clear_input_i,
  input wire logic alarm_reset_input_i,
  input wire logic return_home_req_i,
  // motor side status, asynchronous
  input wire logic sensor_fault_i,
  input wire logic motor_supported_i,
  input wire logic nvm_corrupt_i,
  input wire logic abnormal_data_warn_i,
  // position and speed from core logic
  input wire logic cmd_step_i,
  input wire logic cmd_dir_i,
  input wire logic act_step_i,
  input wire logic act_dir_i,
  input wire logic [15:0] shaft_speed_rpm_i,
  input wire logic [31:0] gear_resolution_i,
  // register port
  input wire logic [fault_mon_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [fault_mon_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [fault_mon_pkg::DATA_W-1:0] reg_rdata_o,
  // status outputs
  output logic warning_output_o,
  output logic alarm_o,
  output logic [fault_mon_pkg::CODE_W-1:0] alarm_code_o,
  output logic motor_current_cut_o,
  output logic init_done_o
);
  localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);

  logic [fault_mon_pkg::PIN_COUNT-1:0] pins;
  logic current_on;
  logic current_on_d;
  logic alarm_reset_input_d;
  logic home_d;
  fault_mon_pkg::phase_t phase;
  logic [31:0] init_cnt;
  logic signed [31:0] deviation;
  logic [31:0] abs_dev;
  logic [31:0] alm_limit_on;
  logic [31:0] wrn_limit_on;
  logic [31:0] limit_off;
  logic auto_return;
  logic [2:0] warn_prev;
  logic [2:0] warn_pend;

  pin_sync #(
    .WIDTH(fault_mon_pkg::PIN_COUNT)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({abnormal_data_warn_i, nvm_corrupt_i, motor_supported_i, sensor_fault_i,
              return_home_req_i, alarm_reset_input_i, deviation_clear_input_i,
              current_enable_i}),
    .sync_o(pins)
  );

  assign current_on = pins[fault_mon_pkg::PIN_CURRENT_EN];

  // register decode
  wire wr_ctrl = reg_we_i && (reg_addr_i == fault_mon_pkg::REG_CTRL);
  wire wr_alm = reg_we_i && (reg_addr_i == fault_mon_pkg::REG_ALM_LIMIT_ON);
  wire wr_wrn = reg_we_i && (reg_addr_i == fault_mon_pkg::REG_WRN_LIMIT_ON);
  wire wr_off = reg_we_i && (reg_addr_i == fault_mon_pkg::REG_LIMIT_OFF);
  wire hist_clear = wr_ctrl && reg_wdata_i[fault_mon_pkg::CTRL_HIST_CLEAR];
  wire sw_alm_reset = wr_ctrl && reg_wdata_i[fault_mon_pkg::CTRL_ALM_RESET];

  // position deviation
  wire signed [31:0] cmd_delta = cmd_step_i ? (cmd_dir_i ? -32'sd1 : 32'sd1) : 32'sd0;
  wire signed [31:0] act_delta = act_step_i ? (act_dir_i ? -32'sd1 : 32'sd1) : 32'sd0;
  wire signed [31:0] next_deviation = deviation + cmd_delta - act_delta;
  // magnitude only; a 32-bit count cannot overflow within any real move
  assign abs_dev = deviation[31] ? 32'(-deviation) : 32'(deviation);
  // clear pin wins over a step in the same cycle

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || pins[fault_mon_pkg::PIN_DEV_CLEAR]) begin
      deviation <= '0;
    end else begin
      deviation <= next_deviation;
    end
  end

  // configuration registers
  // a new limit acts from the next compare on
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      alm_limit_on <= fault_mon_pkg::RST_ALM_LIMIT_ON;
      wrn_limit_on <= fault_mon_pkg::RST_WRN_LIMIT_ON;
      limit_off <= fault_mon_pkg::RST_LIMIT_OFF;
      auto_return <= fault_mon_pkg::RST_AUTO_RETURN;
    end else begin
      if (wr_alm) alm_limit_on <= reg_wdata_i;
      if (wr_wrn) wrn_limit_on <= reg_wdata_i;
      if (wr_off) limit_off <= reg_wdata_i;
      if (wr_ctrl) auto_return <= reg_wdata_i[fault_mon_pkg::CTRL_AUTO_RETURN];
    end
  end

  // power-up initialisation window
  // gear resolution is judged once, at the last init cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      phase <= fault_mon_pkg::PHASE_INIT;
      init_cnt <= '0;
    end else begin
      case (phase)
        fault_mon_pkg::PHASE_INIT: begin
          init_cnt <= init_cnt + 32'h0000_0001;
          if (init_cnt == INIT_LAST) phase <= fault_mon_pkg::PHASE_RUN;
        end
        default: begin
          init_cnt <= init_cnt;
        end
      endcase
    end
  end

  wire in_init = (phase == fault_mon_pkg::PHASE_INIT);
  wire init_end = in_init && (init_cnt == INIT_LAST);
  // the synchroniser holds reset zeros for two edges and a low motor pin
  // means unsupported, so the motor check waits for real pin values
  wire pins_valid = !in_init || (init_cnt >= 32'(fault_mon_pkg::SYNC_STAGES));

  // warning conditions, levels straight from their causes
  wire warn_dev_on = current_on && (abs_dev > wrn_limit_on);
  wire warn_dev_off = !current_on && auto_return && (abs_dev > limit_off);
  wire warn_abn = pins[fault_mon_pkg::PIN_ABN_WARN];
  wire [2:0] warn_now = {warn_abn, warn_dev_off, warn_dev_on};
  wire any_warn = |warn_now;

  // each new warning queued for the history; one logged per cycle
  // a warning that stays active is logged only once
  wire [2:0] warn_rise = warn_now & ~warn_prev;
  wire [2:0] pend_all = warn_pend | warn_rise;
  wire [2:0] pend_pick = pend_all & (~pend_all + 3'b001);
  wire hist_push = |pend_all;
  wire [fault_mon_pkg::CODE_W-1:0] hist_code = pend_pick[0] ? fault_mon_pkg::CODE_DEV_ON :
                                              pend_pick[1] ? fault_mon_pkg::CODE_DEV_OFF :
                                                             fault_mon_pkg::CODE_ABN_DATA;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      warn_prev <= '0;
      warn_pend <= '0;
    end else begin
      warn_prev <= warn_now;
      warn_pend <= pend_all & ~pend_pick;
    end
  end

  // alarm causes in priority order, lower index wins
  wire gear_bad = (gear_resolution_i < fault_mon_pkg::GEAR_RES_MIN) ||
                  (gear_resolution_i > fault_mon_pkg::GEAR_RES_MAX);
  wire sensor_bad = pins[fault_mon_pkg::PIN_SENSOR_FAULT];
  wire [8:0] alm_cause;
  assign alm_cause[0] = pins[fault_mon_pkg::PIN_NVM_BAD];
  assign alm_cause[1] = pins_valid && !pins[fault_mon_pkg::PIN_MOTOR_OK];
  assign alm_cause[2] = in_init && sensor_bad;
  assign alm_cause[3] = in_init && (shaft_speed_rpm_i >= fault_mon_pkg::INIT_SPEED_LIMIT_RPM);
  assign alm_cause[4] = init_end && gear_bad;
  assign alm_cause[5] = !in_init && current_on && sensor_bad;
  assign alm_cause[6] = current_on && (abs_dev > alm_limit_on);
  // enable edge, so a held enable raises it once
  assign alm_cause[7] = current_on && !current_on_d && warn_prev[1];
  assign alm_cause[8] = pins[fault_mon_pkg::PIN_RETURN_HOME] && !home_d && warn_abn;

  // one code per latch; priority keeps simultaneous causes deterministic
  logic [fault_mon_pkg::CODE_W-1:0] cause_code;
  always_comb begin
    cause_code = fault_mon_pkg::CODE_NONE;
    if (alm_cause[0]) cause_code = fault_mon_pkg::CODE_STORED_DATA;
    else if (alm_cause[1]) cause_code = fault_mon_pkg::CODE_MOTOR_COMBO;
    else if (alm_cause[2]) cause_code = fault_mon_pkg::CODE_INIT_SENSOR;
    else if (alm_cause[3]) cause_code = fault_mon_pkg::CODE_INIT_ROTATION;
    else if (alm_cause[4]) cause_code = fault_mon_pkg::CODE_GEAR;
    else if (alm_cause[5]) cause_code = fault_mon_pkg::CODE_RUN_SENSOR;
    else if (alm_cause[6]) cause_code = fault_mon_pkg::CODE_DEV_ON;
    else if (alm_cause[7]) cause_code = fault_mon_pkg::CODE_DEV_OFF;
    else if (alm_cause[8]) cause_code = fault_mon_pkg::CODE_ABN_DATA;
  end

  wire new_alarm = |alm_cause;
  // only deviation and abnormal-data alarms give way to a reset
  // fatal codes wait for a power cycle once the cause is fixed
  wire resettable = (alarm_code_o == fault_mon_pkg::CODE_DEV_ON) ||
                    (alarm_code_o == fault_mon_pkg::CODE_DEV_OFF) ||
                    (alarm_code_o == fault_mon_pkg::CODE_ABN_DATA);
  // a held pin never resets; only its falling edge does
  wire pin_reset = alarm_reset_input_d && !pins[fault_mon_pkg::PIN_ALM_RESET];
  wire do_reset = alarm_o && resettable && (pin_reset || sw_alm_reset);
  wire next_cut = (cause_code != fault_mon_pkg::CODE_ABN_DATA);

  // first alarm is latched; a new cause in the reset cycle wins
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      alarm_o <= 1'b0;
      alarm_code_o <= fault_mon_pkg::CODE_NONE;
      motor_current_cut_o <= 1'b0;
    end else if (new_alarm && (!alarm_o || do_reset)) begin
      alarm_o <= 1'b1;
      alarm_code_o <= cause_code;
      motor_current_cut_o <= next_cut;
    end else if (do_reset) begin
      alarm_o <= 1'b0;
      alarm_code_o <= fault_mon_pkg::CODE_NONE;
      motor_current_cut_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      current_on_d <= 1'b0;
      alarm_reset_input_d <= 1'b0;
      home_d <= 1'b0;
      warning_output_o <= 1'b0;
      init_done_o <= 1'b0;
    end else begin
      current_on_d <= current_on;
      alarm_reset_input_d <= pins[fault_mon_pkg::PIN_ALM_RESET];
      home_d <= pins[fault_mon_pkg::PIN_RETURN_HOME];
      // warning never touches the current cut; follows causes directly
      warning_output_o <= any_warn;
      init_done_o <= !in_init;
    end
  end

  // history, cleared by power-up reset or software
  logic [fault_mon_pkg::CODE_W-1:0] hist_rd_code;
  logic [fault_mon_pkg::HIST_IDX_W-1:0] hist_count;
  localparam int ADDR_OFF_W = fault_mon_pkg::ADDR_W;
  wire [ADDR_OFF_W-1:0] hist_off = reg_addr_i - fault_mon_pkg::REG_HIST_BASE;

  warning_history u_history (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(hist_clear),
    .push_i(hist_push),
    .code_i(hist_code),
    .rd_idx_i(hist_off[5:2]),
    .rd_code_o(hist_rd_code),
    .count_o(hist_count)
  );

  // read mux
  wire is_hist = (reg_addr_i >= fault_mon_pkg::REG_HIST_BASE) &&
                 (hist_off < 8'(fault_mon_pkg::HIST_DEPTH * 4)) && (hist_off[1:0] == 2'b00);
  wire [31:0] status_word = {17'h0_0000, alarm_code_o, 4'h0, motor_current_cut_o,
                             init_done_o, alarm_o, warning_output_o};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr_i == fault_mon_pkg::REG_CTRL) rd_mux = {31'h0000_0000, auto_return};
    else if (reg_addr_i == fault_mon_pkg::REG_ALM_LIMIT_ON) rd_mux = alm_limit_on;
    else if (reg_addr_i == fault_mon_pkg::REG_WRN_LIMIT_ON) rd_mux = wrn_limit_on;
    else if (reg_addr_i == fault_mon_pkg::REG_LIMIT_OFF) rd_mux = limit_off;
    else if (reg_addr_i == fault_mon_pkg::REG_STATUS) rd_mux = status_word;
    else if (reg_addr_i == fault_mon_pkg::REG_DEVIATION) rd_mux = deviation;
    else if (reg_addr_i == fault_mon_pkg::REG_HIST_COUNT) rd_mux = {28'h000_0000, hist_count};
    else if (is_hist) rd_mux = {25'h000_0000, hist_rd_code};
  end

  // zero outside the read cycle, so stale data never looks valid
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_re_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= '0;
    end
  end
endmodule // motor_fault_warning_monitor
`default_nettype wire

/* File: verif/fault_mon_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fault_mon_sva #(
  parameter int INIT_CYCLES = 20
) (
  // watched ports
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic deviation_clear_input_i,
  input wire logic alarm_reset_input_i,
  input wire logic abnormal_data_warn_i,
  input wire logic reg_we_i,
  input wire logic warning_output_o,
  input wire logic alarm_o,
  input wire logic [6:0] alarm_code_o,
  input wire logic motor_current_cut_o,
  input wire logic init_done_o
);
  logic [15:0] cyc;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) cyc <= 16'h0000;
    else if (cyc != 16'hFFFF) cyc <= cyc + 16'h0001;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence abn_held;
    (init_done_o && abnormal_data_warn_i)[*4];
  endsequence
  sequence causes_gone;
    (deviation_clear_input_i && !abnormal_data_warn_i)[*5];
  endsequence
  rst_idle_a: assert property ($fell(sys_rst_i) |-> !warning_output_o && !alarm_o && !init_done_o)
    else $error("outputs not idle after reset");
  warn_raise_a: assert property (abn_held |-> warning_output_o)
    else $error("warning output missing");
  warn_clear_a: assert property (causes_gone |-> !warning_output_o)
    else $error("warning output stuck");
  cut_match_a: assert property (motor_current_cut_o == (alarm_o && alarm_code_o != 7'h46))
    else $error("current cut mismatch");
  alarm_hold_a: assert property ((alarm_o && alarm_reset_input_i && !reg_we_i)[*5] |=> alarm_o)
    else $error("alarm cleared before reset falls");
  sticky_alarm_a: assert property (alarm_o && alarm_code_o inside {7'h47, 7'h1C, 7'h29, 7'h2A,
    7'h2B, 7'h2D} |=> alarm_o && $stable(alarm_code_o)) else $error("fatal alarm lost");
  code_valid_a: assert property ((alarm_o && alarm_code_o inside {7'h0A, 7'h0C, 7'h46, 7'h47,
    7'h1C, 7'h29, 7'h2A, 7'h2B, 7'h2D}) || (!alarm_o && alarm_code_o == 7'h00))
    else $error("bad alarm code");
  init_time_a: assert property ($rose(init_done_o) |-> cyc >= INIT_CYCLES - 1 && cyc <= INIT_CYCLES + 2)
    else $error("init window length wrong");
  init_only_a: assert property ($rose(alarm_o) && alarm_code_o inside {7'h2A, 7'h2B} |-> !$past(init_done_o, 2))
    else $error("init alarm after init");
  run_only_a: assert property ($rose(alarm_o) && alarm_code_o == 7'h1C |-> init_done_o)
    else $error("running sensor alarm during init");
endmodule // fault_mon_sva
bind motor_fault_warning_monitor fault_mon_sva #(.INIT_CYCLES(INIT_CYCLES)) i_fault_mon_sva (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .deviation_clear_input_i(deviation_clear_input_i),
  .alarm_reset_input_i(alarm_reset_input_i), .abnormal_data_warn_i(abnormal_data_warn_i),
  .reg_we_i(reg_we_i), .warning_output_o(warning_output_o), .alarm_o(alarm_o),
  .alarm_code_o(alarm_code_o), .motor_current_cut_o(motor_current_cut_o), .init_done_o(init_done_o));
`default_nettype wire

/* File: verif/host_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
  // clock
  input wire logic core_clk_i,
  // control pins
  output logic deviation_clear_o,
  output logic alarm_reset_o,
  output logic return_home_o,
  output logic current_enable_o
);
  logic [3:0] pins = 4'h0;
  assign {current_enable_o, return_home_o, alarm_reset_o, deviation_clear_o} = pins;
  // reset acts only once the pin is lowered again
  task automatic set_pin(input int sel, input logic v);
    @(posedge core_clk_i);
    pins[sel] <= v;
  endtask
endmodule // host_ctrl_model
`default_nettype wire

/* File: verif/motor_fault_warning_monitor_test.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_fault_warning_monitor_test;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sensor_fault_i = 1'b0;
  logic motor_supported_i = 1'b1;
  logic nvm_corrupt_i = 1'b0;
  logic abnormal_data_warn_i = 1'b0;
  logic cmd_step_i = 1'b0;
  logic act_step_i = 1'b0;
  logic cmd_dir_i = 1'b0;
  logic act_dir_i = 1'b0;
  logic [15:0] shaft_speed_rpm_i = 16'h0000;
  logic [31:0] gear_resolution_i = 32'h0000_03E8;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  logic [6:0] codes[7] = '{7'h29, 7'h2D, 7'h2A, 7'h2B, 7'h47, 7'h1C, 7'h00};
  wire logic dev_clr, alarm_reset_input, home_req, cur_en;
  wire logic [31:0] rdata;
  int err_total = 0;
  int total_checks = 0;
  int i;
  always #12.5 core_clk_i = ~core_clk_i;
  host_ctrl_model i_host_ctrl_model (.core_clk_i(core_clk_i), .deviation_clear_o(dev_clr),
    .alarm_reset_o(alarm_reset_input), .return_home_o(home_req), .current_enable_o(cur_en));
  motor_fault_warning_monitor #(.INIT_CYCLES(20)) i_motor_fault_warning_monitor (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .current_enable_i(cur_en),
    .deviation_clear_input_i(dev_clr), .alarm_reset_input_i(alarm_reset_input), .return_home_req_i(home_req),
    .sensor_fault_i(sensor_fault_i), .motor_supported_i(motor_supported_i),
    .nvm_corrupt_i(nvm_corrupt_i), .abnormal_data_warn_i(abnormal_data_warn_i),
    .cmd_step_i(cmd_step_i), .cmd_dir_i(cmd_dir_i), .act_step_i(act_step_i),
    .act_dir_i(act_dir_i),
    .shaft_speed_rpm_i(shaft_speed_rpm_i), .gear_resolution_i(gear_resolution_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(rdata), .warning_output_o(), .alarm_o(), .alarm_code_o(),
    .motor_current_cut_o(), .init_done_o());
  function automatic logic [31:0] st(input logic [3:0] b, input logic [6:0] c);
    return {17'h0_0000, c, 4'h0, b};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    reg_re_i <= 1'b0;
  endtask
  task automatic chk_rd(input logic [31:0] e);
    total_checks++;
    if (rdata !== e) begin
      err_total++;
      $display("unexpected read at %0t: got %h want %h", $time, rdata, e);
    end
  endtask
  // data stand only in the cycle after the strobe
  always @(posedge core_clk_i) begin
    rd_pend <= reg_re_i;
    if (rd_pend) chk_rd(exp_q.pop_front());
  end
  task automatic settle;
    repeat (8) @(posedge core_clk_i);
  endtask
  task automatic steps(input int n, input logic act);
    repeat (n) begin
      @(posedge core_clk_i);
      cmd_step_i <= !act;
      act_step_i <= act;
      @(posedge core_clk_i);
      cmd_step_i <= 1'b0;
      act_step_i <= 1'b0;
    end
    settle();
  endtask
  task automatic power_up;
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (30) @(posedge core_clk_i);
  endtask
  task automatic pin(input int sel, input logic v);
    i_host_ctrl_model.set_pin(sel, v);
    settle();
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    $display("unexpected hang at %0t", $time);
    wrap_up();
  end
  initial begin
    rnd = $urandom(32'h59b977bb);
    gear_resolution_i <= $urandom_range(10000, 100);
    power_up();
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_2710);
    rd(8'h08, 32'h0000_1388);
    rd(8'h0C, 32'h0000_2710);
    rd(8'h18, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(8'h04, rnd);
    rd(8'h04, rnd);
    wr(8'h04, 32'h0000_0008);
    wr(8'h08, 32'h0000_0005);
    wr(8'h0C, 32'h0000_0003);
    pin(3, 1'b1);
    steps(5, 1'b0);
    rd(8'h10, st(4'h4, 7'h00));
    steps(1, 1'b0);
    rd(8'h10, st(4'h5, 7'h00));
    rd(8'h14, 32'h0000_0006);
    rd(8'h40, 32'h0000_000A);
    steps(6, 1'b1);
    rd(8'h10, st(4'h4, 7'h00));
    cmd_dir_i <= 1'b1;
    act_dir_i <= 1'b1;
    steps(6, 1'b0);
    rd(8'h10, st(4'h5, 7'h00));
    rd(8'h14, 32'hFFFF_FFFA);
    steps(6, 1'b1);
    cmd_dir_i <= 1'b0;
    act_dir_i <= 1'b0;
    steps(9, 1'b0);
    pin(0, 1'b1);
    pin(1, 1'b1);
    rd(8'h14, 32'h0000_0000);
    rd(8'h10, st(4'hE, 7'h0A));
    pin(1, 1'b0);
    pin(0, 1'b0);
    rd(8'h10, st(4'h4, 7'h00));
    pin(3, 1'b0);
    steps(4, 1'b0);
    rd(8'h10, st(4'h4, 7'h00));
    wr(8'h00, 32'h0000_0001);
    settle();
    rd(8'h10, st(4'h5, 7'h00));
    pin(3, 1'b1);
    rd(8'h10, st(4'hE, 7'h0C));
    wr(8'h00, 32'h0000_0004);
    settle();
    rd(8'h10, st(4'h4, 7'h00));
    pin(0, 1'b1);
    pin(1, 1'b1);
    pin(1, 1'b0);
    pin(0, 1'b0);
    wr(8'h00, 32'h0000_0000);
    abnormal_data_warn_i <= 1'b1;
    settle();
    rd(8'h10, st(4'h5, 7'h00));
    pin(2, 1'b1);
    rd(8'h10, st(4'h7, 7'h46));
    pin(2, 1'b0);
    pin(1, 1'b1);
    pin(1, 1'b0);
    rd(8'h10, st(4'h5, 7'h00));
    steps(6, 1'b0);
    abnormal_data_warn_i <= 1'b0;
    settle();
    rd(8'h10, st(4'h5, 7'h00));
    steps(6, 1'b1);
    rd(8'h10, st(4'h4, 7'h00));
    for (i = 0; i < 6; i++) begin
      abnormal_data_warn_i <= 1'b1;
      settle();
      abnormal_data_warn_i <= 1'b0;
      settle();
    end
    rd(8'h18, 32'h0000_000A);
    rd(8'h40, 32'h0000_0046);
    rd(8'h60, 32'h0000_000C);
    rd(8'h64, 32'h0000_000A);
    wr(8'h00, 32'h0000_0002);
    rd(8'h18, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    // one power cycle per fatal cause; the last one just misses the speed limit
    for (i = 0; i < 7; i++) begin
      nvm_corrupt_i <= (i == 0);
      motor_supported_i <= (i != 1);
      sensor_fault_i <= (i == 2);
      shaft_speed_rpm_i <= (i == 3) ? 16'h000F : (i == 6) ? 16'h000E : 16'h0000;
      gear_resolution_i <= (i == 4) ? 32'h0000_0063 : 32'h0000_2710;
      power_up();
      sensor_fault_i <= (i == 2) || (i == 5);
      pin(1, 1'b1);
      pin(1, 1'b0);
      rd(8'h18, 32'h0000_0000);
      rd(8'h10, (codes[i] == 7'h00) ? st(4'h4, 7'h00) : st(4'hE, codes[i]));
    end
    settle();
    wrap_up();
  end
endmodule // motor_fault_warning_monitor_test
`default_nettype wire
